/* verilog/spf_pkg.sv */
/*
  Package for the self-programming flash controller: register offset,
  bit positions, command patterns, lock-byte layout, timing counts and
  the structs carried on the core and flash-array ports.
  Assumes a 50 MHz system clock and a 64-word, 256-page program flash.
*/
package spf_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [5:0] SPCS_OFFSET = 6'h37;
  localparam logic [7:0] SPCS_RESET = 8'h00;
  localparam int IRQ_EN_BIT = 7;
  localparam int RW_BUSY_BIT = 6;
  localparam int REENABLE_BIT = 4;
  localparam int STORE_EN_BIT = 0;

  // lower five bits: reenable, lock set, page write, page erase, enable
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCK_SET = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
  localparam logic [4:0] CMD_BUF_FILL = 5'h01;
  localparam logic [4:0] CMD_NONE = 5'h00;

  // ------------------------------------------------------------------
  // lock byte
  // ------------------------------------------------------------------
  localparam logic [7:0] LOCK_UNPROGRAMMED = 8'hFF;
  localparam int GEN_LOCK_LO = 0;
  localparam int GEN_LOCK_HI = 1;
  localparam int APP_LOCK_LO = 2;
  localparam int APP_LOCK_HI = 3;
  localparam int BOOT_LOCK_LO = 4;
  localparam int BOOT_LOCK_HI = 5;

  // ------------------------------------------------------------------
  // geometry and timing
  // ------------------------------------------------------------------
  localparam int PAGE_WORDS = 64;
  localparam logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hE0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [2:0] LPM_WINDOW_MIN = 3'h2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_TIME_MIN_NS = 3700000;
  localparam int OP_TIME_MAX_NS = 4500000;
  localparam int OP_CYCLES_DFLT =
    (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_CNT_W = 18;

  typedef struct packed {
    logic spm;
    logic lpm;
    logic [15:0] z;
    logic [7:0] r0;
    logic [7:0] r1;
  } spf_core_req_t;

  typedef struct packed {
    logic erase_start;
    logic write_valid;
    logic [7:0] page;
    logic [5:0] word;
    logic [15:0] data;
  } spf_flash_cmd_t;

endpackage

/* verilog/spf_ctrl.sv */
/*
  Self-programming flash controller: control/status register, timed
  store-program sequencing, temporary page buffer, lock byte and the
  protection decodes derived from it.
  Assumes the core, the flash array and the fuse logic all run on
  clk_sys_i; the flash array takes words and erase starts as given on
  flash_cmd_o and the lock byte is persisted outside via lock_byte_o.
*/
// How it works
// [R1] ready irq while enabled, gie set, enable clear
// [R2] rww erase/write sets section busy flag
// [R3] busy clears by reenable or buffer fill
// [R4] bit five reads zero, writes ignored
// [R5] reenable command after idle makes section readable
// [R6] no reenable while erase/write in progress
// [R7] reenable write during fill discards buffer
// [R8] lock set programs lock bits from low data
// [R9] lock set clears on completion or timeout
// [R10] lpm in three cycles returns lock/fuse
// [R11] page write copies buffer to pointer page
// [R12] page write clears on completion or timeout
// [R13] no_read_while_write_section erase/write stalls core throughout
// [R14] page erase clears pointer page, self clears
// [R15] plain enable stores data word in buffer
// [R16] enable arms four cycles, held during operation
// [R17] only five low-bit patterns take effect
// [R18] six lock bits, one means unprogrammed
// [R19] only chip erase raises lock bits
// [R20] general lock modes gate external access
// [R21] application lock modes gate spm/lpm, irqs
// [R22] boot lock modes gate spm/lpm, irqs
// [R23] timed operations last 3.7 to 4.5 ms
// [R24] page from z14:7, word from z6:1
// [R25] words 0x3800 upward form no-rww section
// [R26] spm outside armed window does nothing
// [R27] protected targets rejected, command bits cleared
`timescale 1ns/1ps

module spf_ctrl #(
  parameter int OP_CYCLES = spf_pkg::OP_CYCLES_DFLT
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [5:0] io_addr_i,
  input wire logic io_we_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire spf_pkg::spf_core_req_t core_req_i,
  input wire logic gie_i,
  input wire logic pc_in_boot_i,
  input wire logic vectors_in_boot_i,
  input wire logic [13:0] boot_start_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] lock_load_i,
  input wire logic chip_erase_i,
  output logic irq_o,
  output logic stall_o,
  output logic rww_access_block_o,
  output logic lpm_block_o,
  output logic irq_mask_o,
  output logic lpm_valid_o,
  output logic [7:0] lpm_data_o,
  output spf_pkg::spf_flash_cmd_t flash_cmd_o,
  output logic [7:0] lock_byte_o,
  output logic ext_prog_lock_o,
  output logic ext_verify_lock_o,
  output logic fuse_lock_o,
  output logic boot_bits_lock_o
);
  import spf_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (OP_CYCLES < 2 || OP_CYCLES >= (1 << OP_CNT_W)) begin : g_chk
    $error("spf_ctrl: OP_CYCLES out of range");
  end

  if (ARM_WINDOW <= LPM_WINDOW_MIN) begin : g_chk_win
    $error("spf_ctrl: read-back window exceeds arm window");
  end

  localparam logic [OP_CNT_W-1:0] OP_LOAD = OP_CYCLES[OP_CNT_W-1:0];

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPF_IDLE = 2'b00,
    SPF_ARMED = 2'b01,
    SPF_BUSY = 2'b11
  } spf_phase_t;

  typedef struct packed {
    spf_phase_t phase;
    logic irq_en;
    logic rw_busy;
    logic [4:0] cmd;
    logic [2:0] win;
    logic op_no_read_while_write_section;
    logic [OP_CNT_W-1:0] op_cnt;
    logic [7:0] page;
    logic [6:0] wr_idx;
    logic loading;
    logic [7:0] lock;
    logic lpm_valid;
    logic [7:0] lpm_data;
    spf_flash_cmd_t fcmd;
    logic [PAGE_WORDS-1:0][15:0] buffer;
  } spf_state_t;

  spf_state_t st;
  spf_state_t next_st;

  // ------------------------------------------------------------------
  // lock decodes
  // ------------------------------------------------------------------
  // a programmed lo bit refuses spm writes; a programmed hi bit refuses
  // lpm reads from the other section and masks irqs there
  logic app_wr_lock;
  logic boot_wr_lock;
  logic app_rd_lock;
  logic boot_rd_lock;

  assign app_wr_lock = !st.lock[APP_LOCK_LO]; // see [R21]
  assign boot_wr_lock = !st.lock[BOOT_LOCK_LO]; // see [R22]
  assign app_rd_lock = !st.lock[APP_LOCK_HI]; // see [R21]
  assign boot_rd_lock = !st.lock[BOOT_LOCK_HI]; // see [R22]

  // ------------------------------------------------------------------
  // decodes
  // ------------------------------------------------------------------
  logic reg_wr;
  logic pattern_ok;
  logic spm_hit;
  logic [7:0] z_page;
  logic z_in_boot;
  logic z_no_read_while_write_section;
  logic z_write_locked;
  logic rearm;

  assign reg_wr = io_we_i && (io_addr_i == SPCS_OFFSET);
  assign pattern_ok = (io_wdata_i[4:0] == CMD_REENABLE) ||
                      (io_wdata_i[4:0] == CMD_LOCK_SET) ||
                      (io_wdata_i[4:0] == CMD_PAGE_WRITE) ||
                      (io_wdata_i[4:0] == CMD_PAGE_ERASE) ||
                      (io_wdata_i[4:0] == CMD_BUF_FILL); // see [R17]
  // a store-program only counts inside the armed window, see [R26]
  assign spm_hit = core_req_i.spm && (st.phase == SPF_ARMED) &&
                   (st.win != 3'h0);
  assign z_page = core_req_i.z[14:7]; // see [R24]
  assign z_in_boot = (core_req_i.z[14:1] >= boot_start_i);
  assign z_no_read_while_write_section = (z_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE); // see [R25]
  // spm writes blocked by app/boot lo lock bit, see [R21] [R22]
  assign z_write_locked = z_in_boot ? boot_wr_lock
                                    : app_wr_lock;
  // a command write taken this cycle restarts the window; it must win
  // over the countdown below or a re-arm would be lost
  assign rearm = reg_wr && pattern_ok &&
                 (st.phase != SPF_BUSY); // see [R16]

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.lpm_valid = 1'b0;
    next_st.fcmd.erase_start = 1'b0;
    next_st.fcmd.write_valid = 1'b0;

    // register write; bit 6 and bit 5 are not writable, see [R4]
    if (reg_wr) begin
      next_st.irq_en = io_wdata_i[IRQ_EN_BIT];
      // refused while an erase/write/lock op runs, see [R6]
      if (st.phase != SPF_BUSY) begin
        if (io_wdata_i[REENABLE_BIT] && st.loading) begin
          // abort the fill: everything loaded so far is lost, see [R7]
          next_st.loading = 1'b0;
          next_st.buffer = {PAGE_WORDS{ERASED_WORD}};
        end
        if (pattern_ok) begin
          next_st.cmd = io_wdata_i[4:0];
          next_st.win = ARM_WINDOW; // see [R16]
          next_st.phase = SPF_ARMED;
        end
      end
    end

    case (st.phase)
      SPF_IDLE: begin
      end
      SPF_ARMED: begin
        if (spm_hit) begin
          next_st.win = 3'h0;
          next_st.phase = SPF_IDLE;
          next_st.cmd = CMD_NONE; // see [R16]
          case (st.cmd)
            CMD_BUF_FILL: begin
              if (!z_write_locked) begin // see [R27]
                // pointer bit 0 is dropped, see [R15]
                next_st.buffer[core_req_i.z[6:1]] =
                  {core_req_i.r1, core_req_i.r0};
                next_st.loading = 1'b1;
                next_st.rw_busy = 1'b0; // see [R3]
              end
            end
            CMD_REENABLE: begin
              next_st.rw_busy = 1'b0; // see [R3] [R5]
            end
            CMD_LOCK_SET: begin
              // and-in only, so no bit goes back to one, see [R8] [R19]
              next_st.lock = st.lock & {2'b11, core_req_i.r0[5:0]};
              next_st.cmd = st.cmd;
              next_st.phase = SPF_BUSY;
              next_st.op_cnt = OP_LOAD; // see [R23]
              next_st.op_no_read_while_write_section = 1'b0;
            end
            CMD_PAGE_WRITE,
            CMD_PAGE_ERASE: begin
              if (!z_write_locked) begin // see [R27]
                next_st.cmd = st.cmd; // see [R16]
                next_st.phase = SPF_BUSY;
                next_st.op_cnt = OP_LOAD; // see [R23]
                next_st.op_no_read_while_write_section = z_no_read_while_write_section;
                next_st.page = z_page; // see [R11] [R14]
                next_st.wr_idx = 7'h00;
                next_st.rw_busy = st.rw_busy || !z_no_read_while_write_section; // see [R2]
                next_st.fcmd.erase_start = (st.cmd == CMD_PAGE_ERASE);
                next_st.fcmd.page = z_page;
                next_st.fcmd.word = 6'h00;
              end
            end
            default: begin
            end
          endcase
        end else if (rearm) begin
          // window already reloaded by the register write above
        end else if (st.win == 3'h1) begin
          // window ran out with no store-program, see [R9] [R12] [R14]
          next_st.win = 3'h0;
          next_st.cmd = CMD_NONE;
          next_st.phase = SPF_IDLE;
        end else begin
          next_st.win = st.win - 3'h1;
        end
        // fuse/lock read-back within three cycles, see [R10]
        if (core_req_i.lpm && (st.cmd == CMD_LOCK_SET) &&
            (st.win >= LPM_WINDOW_MIN)) begin
          next_st.lpm_valid = 1'b1;
          next_st.lpm_data = core_req_i.z[0] ? st.lock : fuse_low_i;
        end
      end
      SPF_BUSY: begin
        // page write streams the buffer word by word at the start
        if ((st.cmd == CMD_PAGE_WRITE) &&
            (st.wr_idx < 7'(PAGE_WORDS))) begin
          next_st.fcmd.write_valid = 1'b1; // see [R11]
          next_st.fcmd.page = st.page;
          next_st.fcmd.word = st.wr_idx[5:0];
          next_st.fcmd.data = st.buffer[st.wr_idx[5:0]];
          next_st.wr_idx = st.wr_idx + 7'h01;
        end
        if (st.op_cnt == {{(OP_CNT_W-1){1'b0}}, 1'b1}) begin
          if (st.cmd == CMD_PAGE_WRITE) begin
            // buffer is consumed by the write
            next_st.loading = 1'b0;
            next_st.buffer = {PAGE_WORDS{ERASED_WORD}};
          end
          next_st.cmd = CMD_NONE; // see [R9] [R12] [R14] [R16]
          next_st.op_no_read_while_write_section = 1'b0;
          next_st.phase = SPF_IDLE;
        end
        next_st.op_cnt = st.op_cnt - {{(OP_CNT_W-1){1'b0}}, 1'b1};
      end
      default: begin
        next_st.phase = SPF_IDLE;
        next_st.cmd = CMD_NONE;
      end
    endcase

    // chip erase is the only path back to unprogrammed, see [R19]
    if (chip_erase_i) begin
      next_st.lock = LOCK_UNPROGRAMMED;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '0;
      st.phase <= SPF_IDLE;
      st.irq_en <= SPCS_RESET[IRQ_EN_BIT];
      st.cmd <= SPCS_RESET[4:0];
      // lock byte is non-volatile: reload the stored copy on reset
      st.lock <= lock_load_i;
      st.buffer <= {PAGE_WORDS{ERASED_WORD}};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    io_rdata_o = 8'h00;
    if (io_addr_i == SPCS_OFFSET) begin
      io_rdata_o = {st.irq_en, st.rw_busy, 1'b0, st.cmd}; // see [R4]
    end
  end

  // level request, held as long as the enable bit stays clear, see [R1]
  assign irq_o = st.irq_en && gie_i && !st.cmd[STORE_EN_BIT];
  // no_read_while_write_section targets halt the core for the whole op, see [R13]
  assign stall_o = (st.phase == SPF_BUSY) && st.op_no_read_while_write_section;
  assign rww_access_block_o = st.rw_busy; // see [R2]

  // lpm across sections, blocked by the hi lock bit, see [R21] [R22]
  assign lpm_block_o = pc_in_boot_i
    ? (!core_req_i.z[15] && !z_in_boot && app_rd_lock)
    : (!core_req_i.z[15] && z_in_boot && boot_rd_lock);
  // interrupt masking when vectors sit in the other section
  assign irq_mask_o =
    (vectors_in_boot_i && !pc_in_boot_i && app_rd_lock) ||
    (!vectors_in_boot_i && pc_in_boot_i &&
     boot_rd_lock); // see [R21] [R22]

  assign lpm_valid_o = st.lpm_valid;
  assign lpm_data_o = st.lpm_data;
  assign flash_cmd_o = st.fcmd;
  assign lock_byte_o = st.lock; // see [R18]

  // general lock: 10 programming/fuses, 00 also verify/boot bits
  assign ext_prog_lock_o = !st.lock[GEN_LOCK_LO]; // see [R20]
  assign fuse_lock_o = !st.lock[GEN_LOCK_LO];
  assign ext_verify_lock_o = !st.lock[GEN_LOCK_LO] &&
                             !st.lock[GEN_LOCK_HI]; // see [R20]
  assign boot_bits_lock_o = !st.lock[GEN_LOCK_LO] &&
                            !st.lock[GEN_LOCK_HI];

endmodule // spf_ctrl

/* tb/spf_core_model.sv */
/*
  Core model: writes the control register and issues one store or load
  program instruction in the first armed cycle.
  Assumes the controller samples every request on clk_sys_i.
*/
`timescale 1ns/1ps
module spf_core_model
  import spf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [7:0] io_rdata_i,
  output logic [5:0] io_addr_o,
  output logic io_we_o,
  output logic [7:0] io_wdata_o,
  output spf_pkg::spf_core_req_t req_o
);
  initial begin
    io_addr_o = SPCS_OFFSET;
    io_we_o = 1'b0;
    io_wdata_o = 8'h00;
    req_o = '0;
  end
  // ------------------------------------------------------------------
  // instruction sequences
  // ------------------------------------------------------------------
  // kind: 0 none, 1 store program, 2 load program
  task automatic cmd(input logic [7:0] d, input int kind,
                     input logic [15:0] z, input logic [15:0] r);
    @(posedge clk_sys_i);
    io_we_o <= 1'b1;
    io_wdata_o <= d;
    @(posedge clk_sys_i);
    io_we_o <= 1'b0;
    io_wdata_o <= ~d; // released bus shows no stale value
    req_o.spm <= (kind == 1);
    req_o.lpm <= (kind == 2);
    req_o.z <= z;
    req_o.r1 <= r[15:8];
    req_o.r0 <= r[7:0];
    @(posedge clk_sys_i);
    req_o.spm <= 1'b0;
    req_o.lpm <= 1'b0;
    req_o.z <= ~z;
    req_o.r1 <= ~r[15:8];
    req_o.r0 <= ~r[7:0];
  endtask
  task automatic peek(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    io_addr_o <= a;
    #1 d = io_rdata_i;
    @(posedge clk_sys_i);
    io_addr_o <= SPCS_OFFSET;
  endtask
endmodule // spf_core_model

/* tb/spf_ctrl_asserts.sv */
/*
  Checker for spf_ctrl, bound to its ports.
  Assumes one clock domain and the synchronous reset rst_i.
*/
`timescale 1ns/1ps
module spf_ctrl_asserts
  import spf_pkg::*;
#(
  parameter int OP_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_rdata_o,
  input wire spf_pkg::spf_core_req_t core_req_i,
  input wire logic gie_i,
  input wire logic chip_erase_i,
  input wire logic irq_o,
  input wire logic stall_o,
  input wire logic rww_access_block_o,
  input wire logic lpm_valid_o,
  input wire spf_pkg::spf_flash_cmd_t flash_cmd_o,
  input wire logic [7:0] lock_byte_o,
  input wire logic ext_prog_lock_o,
  input wire logic ext_verify_lock_o,
  input wire logic fuse_lock_o,
  input wire logic boot_bits_lock_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire sel = io_addr_i == SPCS_OFFSET;
  wire fl_act = flash_cmd_o.write_valid || flash_cmd_o.erase_start;
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  a_irq_level: assert property (sel |-> irq_o ==
    (io_rdata_o[7] && gie_i && !io_rdata_o[0])) else $error("irq level");
  a_bit5_zero: assert property (sel |-> !io_rdata_o[5])
    else $error("reserved bit set");
  a_busy_mirror: assert property (sel |->
    io_rdata_o[6] == rww_access_block_o) else $error("busy mismatch");
  a_rww_busy: assert property (fl_act &&
    flash_cmd_o.page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> rww_access_block_o && !stall_o)
    else $error("rww op without busy");
  a_no_read_while_write_section_stall: assert property (fl_act &&
    flash_cmd_o.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> stall_o)
    else $error("no_read_while_write_section op without stall");
  a_stall_armed: assert property (stall_o && sel |->
    io_rdata_o[0]) else $error("stall with enable clear");
  a_erase_page: assert property (flash_cmd_o.erase_start |->
    $past(core_req_i.spm) && flash_cmd_o.page == $past(core_req_i.z[14:7]))
    else $error("erase page wrong");
  a_lock_no_raise: assert property (!$past(chip_erase_i) &&
    !$past(rst_i) |-> (lock_byte_o & ~$past(lock_byte_o)) == 8'h00)
    else $error("lock bit raised");
  a_ext_locks: assert property (
    ext_prog_lock_o == !lock_byte_o[0] && fuse_lock_o == !lock_byte_o[0] &&
    boot_bits_lock_o == ext_verify_lock_o &&
    ext_verify_lock_o == (lock_byte_o[1:0] == 2'b00))
    else $error("lock mode decode");
  a_lpm_pulse: assert property (lpm_valid_o |->
    $past(core_req_i.lpm) && !$past(lpm_valid_o)) else $error("lpm pulse");
endmodule // spf_ctrl_asserts

bind spf_ctrl spf_ctrl_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk_sys_i, .rst_i, .io_addr_i, .io_rdata_o, .core_req_i, .gie_i,
  .chip_erase_i, .irq_o, .stall_o, .rww_access_block_o, .lpm_valid_o,
  .flash_cmd_o, .lock_byte_o, .ext_prog_lock_o, .ext_verify_lock_o,
  .fuse_lock_o, .boot_bits_lock_o
);

/* tb/spf_ctrl_tb.sv */
/*
  Bench for spf_ctrl: the core model drives register and instruction
  traffic; queues and a buffer model check words, lock and status.
  Assumes OP_CYCLES shortened so each timed operation ends quickly.
*/
`timescale 1ns/1ps
module spf_ctrl_tb;
  import spf_pkg::*;
  localparam int OPC = 100;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic gie = 1'b0;
  logic chip_erase = 1'b0;
  logic [5:0] io_addr;
  logic io_we, irq, stall, busy, lpm_valid;
  logic [7:0] io_wdata, rdata, lpm_data, lock_byte;
  spf_core_req_t req;
  spf_flash_cmd_t fcmd;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] buf_m [64];
  logic [29:0] wq [$];
  logic [7:0] eq [$];
  logic [7:0] lq [$];
  spf_core_model core (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata),
    .io_addr_o(io_addr), .io_we_o(io_we), .io_wdata_o(io_wdata),
    .req_o(req));
  spf_ctrl #(.OP_CYCLES(OPC)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .io_addr_i(io_addr), .io_we_i(io_we), .io_wdata_i(io_wdata),
    .io_rdata_o(rdata), .core_req_i(req), .gie_i(gie),
    .pc_in_boot_i(1'b0), .vectors_in_boot_i(1'b0),
    .boot_start_i(14'h3800), .fuse_low_i(8'h5A), .lock_load_i(8'hFF),
    .chip_erase_i(chip_erase), .irq_o(irq), .stall_o(stall),
    .rww_access_block_o(busy), .lpm_block_o(), .irq_mask_o(),
    .lpm_valid_o(lpm_valid), .lpm_data_o(lpm_data), .flash_cmd_o(fcmd),
    .lock_byte_o(lock_byte), .ext_prog_lock_o(), .ext_verify_lock_o(),
    .fuse_lock_o(), .boot_bits_lock_o());
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (fcmd.write_valid) wq.push_back({fcmd.page, fcmd.word, fcmd.data});
    if (fcmd.erase_start) eq.push_back(fcmd.page);
    if (lpm_valid) lq.push_back(lpm_data);
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    #1;
    for (int i = 0; i < 1000 && rdata[0] !== 1'b0; i++)
      @(posedge clk_sys_i);
    #1 chk(rdata[0], 0);
  endtask
  task automatic page_check(input logic [7:0] pg);
    wait_idle();
    chk(wq.size(), PAGE_WORDS);
    for (int w = 0; w < PAGE_WORDS; w++) begin
      chk(wq[w], {pg, w[5:0], buf_m[w]});
      buf_m[w] = ERASED_WORD;
    end
    wq.delete();
  endtask
  initial begin
    logic [15:0] d;
    logic [7:0] r;
    logic [5:0] w;
    void'($urandom(98568));
    foreach (buf_m[i]) buf_m[i] = ERASED_WORD;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk(rdata, SPCS_RESET);
    chk(lock_byte, LOCK_UNPROGRAMMED);
    core.cmd(8'hE0, 0, 16'h0, 16'h0);
    #1 chk(rdata, 8'h80);
    @(posedge clk_sys_i) gie <= 1'b1;
    #1 chk(irq, 1);
    for (int i = 0; i < 32; i++) begin
      if (!(i inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})) begin
        core.cmd({3'b100, i[4:0]}, 0, 16'h0, 16'h0);
        #1 chk(rdata, 8'h80);
      end
    end
    core.peek(6'h38, r);
    chk(r, 8'h00);
    core.cmd(8'h01, 0, 16'h0, 16'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(rdata, 8'h01);
    @(posedge clk_sys_i);
    #1 chk(rdata, 8'h00);
    core.cmd(8'h00, 1, 16'h0800, 16'hBEEF); // unarmed
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      w = 6'(i * 3);
      core.cmd(8'h01, 1, {1'b0, 8'h10, w, 1'($urandom)}, d);
      buf_m[w] = d;
      wait_idle();
    end
    core.cmd(8'h05, 1, {1'b0, 8'h10, 7'h0}, 16'h0);
    #1 chk(rdata, 8'h45);
    core.cmd(8'h11, 0, 16'h0, 16'h0);
    #1 chk(rdata, 8'h45);
    chk(busy, 1);
    page_check(8'h10);
    chk(rdata, 8'h40);
    core.cmd(8'h11, 1, 16'h0, 16'h0);
    wait_idle();
    chk(rdata, 8'h00);
    core.cmd(8'h01, 1, {1'b0, 8'hE1, 6'h5, 1'b0}, 16'h1234);
    core.cmd(8'h11, 0, 16'h0, 16'h0); // aborts the fill
    wait_idle();
    core.cmd(8'h03, 1, {1'b0, 8'hE0, 7'h0}, 16'h0);
    #1 chk(stall, 1);
    wait_idle();
    chk(eq.size(), 1);
    chk(eq.pop_front(), 8'hE0);
    core.cmd(8'h05, 1, {1'b0, 8'hE1, 7'h0}, 16'h0);
    page_check(8'hE1);
    core.cmd(8'h09, 2, 16'h0001, 16'h0);
    core.cmd(8'h09, 2, 16'h0000, 16'h0);
    @(posedge clk_sys_i);
    #1 chk(lq.size(), 2);
    chk(lq[0], LOCK_UNPROGRAMMED);
    chk(lq[1], 8'h5A);
    wait_idle();
    core.cmd(8'h09, 1, 16'h0, 16'h0032);
    wait_idle();
    chk(lock_byte, 8'hF2);
    chk(rdata, 8'h00);
    core.cmd(8'h09, 1, 16'h0, 16'h00FF);
    wait_idle();
    chk(lock_byte, 8'hF2);
    core.cmd(8'h03, 1, {1'b0, 8'h10, 7'h0}, 16'h0);
    wait_idle();
    chk(eq.size(), 0);
    chk(rdata, 8'h00);
    @(posedge clk_sys_i) chip_erase <= 1'b1;
    @(posedge clk_sys_i) chip_erase <= 1'b0;
    #1 chk(lock_byte, LOCK_UNPROGRAMMED);
    // read lock only on the application section: writes must still land
    core.cmd(8'h09, 1, 16'h0, 16'h0037);
    wait_idle();
    chk(lock_byte, 8'hF7);
    core.cmd(8'h03, 1, {1'b0, 8'h10, 7'h0}, 16'h0);
    wait_idle();
    chk(eq.size(), 1);
    chk(eq.pop_front(), 8'h10);
    chk(rdata, 8'h40);
    final_report();
  end
endmodule // spf_ctrl_tb
